/* File: pkg/exec_defs.vh */
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define OFS_INSTR     8'h00
`define OFS_ACC       8'h04
`define OFS_STATUS    8'h08
`define OFS_PAGE      8'h0C
`define OFS_PC        8'h10
`define OFS_FILE      8'h14
`define OFS_CYCLES    8'h18

// ==========================================================================
// Instruction word layout
`define IW_HI         13
`define OPC_HI        13
`define OPC_LO        8
`define DIR_BIT       7
`define FADR_HI       6
`define LIT_HI        7
`define BR_TAG_LO     11
`define BR_K_HI       10
`define BR_TAG        3'h5
`define OPC_INCSKIP   6'h0F
`define OPC_INC       6'h0A
`define OPC_ORREG     6'h04
`define OPC_ORLIT     6'h38

// ==========================================================================
// Field positions
`define PAGE_HI       4
`define PAGE_LO       3
`define ST_ZERO       0
`define ST_SKIP       1
`define ST_BUSY       2
`define FA_WE         15
`define FA_ADR_HI     14
`define FA_ADR_LO     8

// ==========================================================================
// Reset values and bus answers
`define RST_ACC       8'h00
`define RST_PAGE      5'h00
`define RST_PC        13'h0000
`define RST_INSTR     14'h0000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

/* File: rtl/exec_alu.v */
// ==========================================================================
// Increment / OR datapath
module exec_alu (
  input  wire       opOr,
  input  wire [7:0] accIn,
  input  wire [7:0] operand,
  output wire [7:0] result,
  output wire       isZero
);

  // Increment wraps 0xFF to 0x00, which is what the skip looks for
  assign result = opOr ? (accIn | operand) : (operand + 8'h01);
  assign isZero = (result == 8'h00);

endmodule // exec_alu

/* File: rtl/file_reg_array.v */
// ==========================================================================
// 128 x 8 register file, one write port, two read ports
module file_reg_array (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       we,
  input  wire [6:0] wAddr,
  input  wire [7:0] wData,
  input  wire [6:0] rAddrA,
  output wire [7:0] rDataA,
  input  wire [6:0] rAddrB,
  output wire [7:0] rDataB
);

  reg [7:0] mem [0:127];

  genvar i;
  generate
    for (i = 0; i < 128; i = i + 1)
    begin : gEntry
      localparam [6:0] IDX = i;
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          mem[i] <= 8'h00;
        else if (ce && we && (wAddr == IDX))
          mem[i] <= wData;
      end
    end
  endgenerate

  assign rDataA = mem[rAddrA];
  assign rDataB = mem[rAddrB];

endmodule // file_reg_array

/* File: rtl/increment_or_branch_exec.v */
`include "exec_defs.vh"

module increment_or_branch_exec (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  output wire [12:0] pcValue,
  output wire [7:0]  accValue,
  output wire        flushCycle
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FLUSH = 1'b1;

  // ========================================================================
  // State
  reg        state_q;
  reg [7:0]  acc_q;
  reg        zero_q;
  reg        skip_q;
  reg [4:0]  page_q;
  reg [12:0] pc_q;
  reg [13:0] instr_q;
  reg [6:0]  fileSel_q;
  reg [31:0] cycles_q;

  reg        awHeld_q;
  reg [7:0]  awAddr_q;
  reg        wHeld_q;
  reg [31:0] wData_q;
  reg [3:0]  wStrb_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  reg        rvalid_q;
  reg [1:0]  rresp_q;
  reg [31:0] rdata_q;

  wire [7:0] fileRdA;
  wire [7:0] fileRdB;

  // ========================================================================
  // Register views for the write merge and the read path
  // Spelled out per process so any register change is seen at once
  reg  [32:0] wrView;
  reg  [32:0] rdView;
  wire [7:0]  rdAddr = {araddr[7:2], 2'b00};

  always @*
  begin
    case (awAddr_q)
      `OFS_INSTR:  wrView = {1'b1, 18'h00000, instr_q};
      `OFS_ACC:    wrView = {1'b1, 24'h000000, acc_q};
      `OFS_STATUS: wrView = {1'b1, 29'h00000000,
                             state_q, skip_q, zero_q};
      `OFS_PAGE:   wrView = {1'b1, 27'h0000000, page_q};
      `OFS_PC:     wrView = {1'b1, 19'h00000, pc_q};
      `OFS_FILE:   wrView = {1'b1, 17'h00000, fileSel_q, fileRdB};
      `OFS_CYCLES: wrView = {1'b1, cycles_q};
      default:     wrView = {1'b0, 32'h00000000};
    endcase
  end

  always @*
  begin
    case (rdAddr)
      `OFS_INSTR:  rdView = {1'b1, 18'h00000, instr_q};
      `OFS_ACC:    rdView = {1'b1, 24'h000000, acc_q};
      `OFS_STATUS: rdView = {1'b1, 29'h00000000,
                             state_q, skip_q, zero_q};
      `OFS_PAGE:   rdView = {1'b1, 27'h0000000, page_q};
      `OFS_PC:     rdView = {1'b1, 19'h00000, pc_q};
      `OFS_FILE:   rdView = {1'b1, 17'h00000, fileSel_q, fileRdB};
      `OFS_CYCLES: rdView = {1'b1, cycles_q};
      default:     rdView = {1'b0, 32'h00000000};
    endcase
  end

  // ========================================================================
  // Write channel handshakes
  wire busy      = (state_q == ST_FLUSH);
  wire wrIsInstr = (awAddr_q == `OFS_INSTR);
  // An instruction written during the flush cycle waits for it to end
  wire doWrite   = ce && awHeld_q && wHeld_q && !bvalid_q &&
                   !(wrIsInstr && busy);

  // Address and data come in either order; each is held until both are in
  assign awready = ce && !awHeld_q && !bvalid_q;
  assign wready  = ce && !wHeld_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  wire        wrHit  = wrView[32];
  wire [31:0] strbMask;

  genvar ln;
  generate
    for (ln = 0; ln < 4; ln = ln + 1)
    begin : gLane
      assign strbMask[ln*8 +: 8] = {8{wStrb_q[ln]}};
    end
  endgenerate

  wire [31:0] wrVal = (wrView[31:0] & ~strbMask) | (wData_q & strbMask);

  // ========================================================================
  // Instruction decode
  wire        issue     = doWrite && wrIsInstr;
  wire [13:0] iw        = wrVal[`IW_HI:0];
  wire [5:0]  opc       = iw[`OPC_HI:`OPC_LO];
  wire        isIncSkip = (opc == `OPC_INCSKIP);
  wire        isInc     = (opc == `OPC_INC);
  wire        isOrReg   = (opc == `OPC_ORREG);
  wire        isOrLit   = (opc == `OPC_ORLIT);
  // Branch owns a 3-bit tag, leaving 11 bits of target
  wire        isBranch  = (iw[`IW_HI:`BR_TAG_LO] == `BR_TAG);
  wire        toReg     = iw[`DIR_BIT];
  wire [6:0]  fAddr     = iw[`FADR_HI:0];
  wire        byteOp    = isIncSkip || isInc || isOrReg;

  // Pending skip turns this instruction into a no-operation
  wire        execOp    = issue && !skip_q;

  wire [7:0]  aluRes;
  wire        aluZero;

  exec_alu uAlu (
    .opOr    (isOrLit || isOrReg),
    .accIn   (acc_q),
    .operand (isOrLit ? iw[`LIT_HI:0] : fileRdA),
    .result  (aluRes),
    .isZero  (aluZero)
  );

  wire accFromOp  = execOp && (isOrLit || (byteOp && !toReg));
  wire fileFromOp = execOp && byteOp && toReg;
  wire zeroFromOp = execOp && (isInc || isOrLit || isOrReg);
  wire branchOp   = execOp && isBranch;

  // ========================================================================
  // Register file port sharing
  // Software and an executing word never write the file in one cycle
  wire swFileWr = doWrite && (awAddr_q == `OFS_FILE) && wrVal[`FA_WE];
  wire       fileWe = fileFromOp || swFileWr;
  wire [6:0] fileWa = fileFromOp ? fAddr :
                      wrVal[`FA_ADR_HI:`FA_ADR_LO];
  wire [7:0] fileWd = fileFromOp ? aluRes : wrVal[7:0];

  file_reg_array uFile (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .we     (fileWe),
    .wAddr  (fileWa),
    .wData  (fileWd),
    .rAddrA (fAddr),
    .rDataA (fileRdA),
    .rAddrB (fileSel_q),
    .rDataB (fileRdB)
  );

  // ========================================================================
  // Execution state
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ST_IDLE;
      acc_q     <= `RST_ACC;
      zero_q    <= 1'b0;
      page_q    <= `RST_PAGE;
      pc_q      <= `RST_PC;
      instr_q   <= `RST_INSTR;
      fileSel_q <= 7'h00;
    end
    else if (ce)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (branchOp)
            state_q <= ST_FLUSH;
        end
        ST_FLUSH:
        begin
          // Second cycle of a branch discards the prefetched word
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
      if (issue)
      begin
        instr_q <= iw;
        if (branchOp)
          pc_q <= {page_q[`PAGE_HI:`PAGE_LO],
                   iw[`BR_K_HI:0]};
        else
          pc_q <= pc_q + 13'h0001;
        if (accFromOp)
          acc_q <= aluRes;
        if (zeroFromOp)
          zero_q <= aluZero;
      end
      if (doWrite)
      begin
        case (awAddr_q)
          `OFS_ACC:    acc_q     <= wrVal[7:0];
          `OFS_STATUS: zero_q    <= wrVal[`ST_ZERO];
          `OFS_PAGE:   page_q    <= wrVal[4:0];
          `OFS_PC:     pc_q      <= wrVal[12:0];
          `OFS_FILE:   fileSel_q <= wrVal[`FA_ADR_HI:`FA_ADR_LO];
          default:     ;
        endcase
      end
    end
  end

  // ========================================================================
  // Pending skip: armed by a zero increment-and-skip, spent by next word
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      skip_q <= 1'b0;
    else if (ce && issue)
      skip_q <= execOp && isIncSkip && aluZero;
  end

  // ========================================================================
  // Instruction cycles: one per issued word, one more per flush cycle
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cycles_q <= 32'h00000000;
    else if (ce && (issue || busy))
      cycles_q <= cycles_q + 32'h00000001;
  end

  // ========================================================================
  // Write address / data capture and response
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
    end
  end

  // ========================================================================
  // Read channel
  // Read data is captured at the address handshake; one read in flight
  assign arready = ce && !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rdView[31:0];
        rresp_q  <= rdView[32] ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && rready)
        rvalid_q <= 1'b0;
    end
  end

  // ========================================================================
  // Observation outputs
  assign pcValue    = pc_q;
  assign accValue   = acc_q;
  assign flushCycle = busy;

endmodule // increment_or_branch_exec

/* File: verif/increment_or_branch_exec_monitor.sv */
`include "exec_defs.vh"

module increment_or_branch_exec_monitor (
  input logic        mclk,
  input logic        rst_n,
  input logic        ce,
  input logic [7:0]  awaddr,
  input logic        awvalid,
  input logic        awready,
  input logic [31:0] wdata,
  input logic        wvalid,
  input logic        wready,
  input logic        bvalid,
  input logic [12:0] pcValue,
  input logic [7:0]  accValue,
  input logic        flushCycle
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Shadow of the last issued instruction
  logic [13:0] insQ;
  logic [12:0] pcQ;
  logic [7:0]  accQ;
  logic [1:0]  pgQ;
  logic        isInsQ;
  logic        skipQ;
  logic        bvQ;
  // Bench offers address and data together, so one edge takes both
  wire take = awvalid && awready && wvalid && wready;
  wire done = bvalid && !bvQ && isInsQ;
  wire isBr = insQ[13:11] == `BR_TAG;

  always_ff @(posedge mclk)
    if (take && awaddr == `OFS_INSTR)
    begin
      insQ <= wdata[13:0];
      pcQ <= pcValue;
      accQ <= accValue;
    end

  always_ff @(posedge mclk)
    if (take && awaddr == `OFS_PAGE)
      pgQ <= wdata[`PAGE_HI:`PAGE_LO];

  // Only a zero seen in the accumulator arms a skip; register results hide
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      isInsQ <= 1'b0;
      skipQ <= 1'b0;
      bvQ <= 1'b0;
    end
    else
    begin
      bvQ <= bvalid;
      if (take)
        isInsQ <= awaddr == `OFS_INSTR;
      if (done)
        skipQ <= !skipQ && insQ[13:8] == `OPC_INCSKIP && !insQ[7]
                 && accValue == 8'h00;
    end

  // ==========
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_flush_one_cycle: assert property (
    flushCycle && ce |=> !flushCycle)
    else $error("flush cycle too long");
  a_flush_on_branch: assert property (
    $rose(flushCycle) |-> isInsQ && isBr)
    else $error("flush without branch");
  a_branch_target: assert property (
    $rose(flushCycle) |-> pcValue == {pgQ, insQ[10:0]})
    else $error("branch target wrong");
  a_branch_keeps_acc: assert property (
    $rose(flushCycle) |-> $stable(accValue))
    else $error("branch changed accumulator");
  a_or_literal: assert property (
    done && !skipQ && insQ[13:8] == `OPC_ORLIT
    |-> accValue == (accQ | insQ[7:0]))
    else $error("literal OR wrong");
  a_no_extra_cycle: assert property (
    done && !isBr |-> !flushCycle && pcValue == pcQ + 13'h0001)
    else $error("extra cycle or bad counter");
  a_skip_noop: assert property (
    done && skipQ |-> $stable(accValue) && !flushCycle)
    else $error("skipped instruction executed");
  a_write_answer: assert property (
    take |-> ##[1:3] bvalid)
    else $error("write response missing");
endmodule // increment_or_branch_exec_monitor

bind increment_or_branch_exec increment_or_branch_exec_monitor mon (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .pcValue(pcValue), .accValue(accValue), .flushCycle(flushCycle)
);

/* File: verif/tb_increment_or_branch_exec.sv */
`include "exec_defs.vh"

module tb_increment_or_branch_exec;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, flushCycle;
  logic [7:0]  awaddr, araddr, accValue;
  logic [31:0] wdata, rdata, d, c0;
  logic [1:0]  bresp, rresp, rs;
  logic [12:0] pcValue;
  int          nFail = 0;
  int          comparisons = 0;
  int          nFl = 0;

  increment_or_branch_exec dut (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pcValue(pcValue), .accValue(accValue),
    .flushCycle(flushCycle)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (flushCycle === 1'b1)
      nFl <= nFl + 1;

  // ==========
  // Bus and compare helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] e);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge mclk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do
    begin
      @(negedge mclk);
      ta = bvalid;
      rs = bresp;
      @(posedge mclk);
    end
    while (!ta);
    chk(rs, e);
  endtask

  task automatic rd(input logic [7:0] a);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge mclk);
      t = arready;
      @(posedge mclk);
    end
    while (!t);
    arvalid <= 1'b0;
    do
    begin
      @(negedge mclk);
      t = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge mclk);
    end
    while (!t);
  endtask

  task automatic ex(input logic [13:0] i);
    wr(`OFS_INSTR, {18'h0, i}, `RESP_OKAY);
  endtask

  function automatic logic [13:0] op(input logic [5:0] o,
                                     input logic r, input logic [6:0] f);
    return {o, r, f};
  endfunction

  // ==========
  // Scenarios
  task automatic tReset;
    for (int i = 0; i < 5; i++)
    begin
      rd(8'(i * 4));
      chk(d, 32'h0);
    end
    rd(8'h1C);
    chk(rs, `RESP_SLVERR);
    wr(8'h1C, 32'hFF, `RESP_SLVERR);
  endtask

  task automatic tSkip;
    wr(`OFS_FILE, 32'hFF05, `RESP_OKAY);
    ex(op(`OPC_INCSKIP, 1'b1, 7'h7F));
    rd(`OFS_FILE);
    chk(d, 32'h7F06);
    ex(op(`OPC_INCSKIP, 1'b0, 7'h7F));
    chk(accValue, 8'h07);
    ex(op(`OPC_ORLIT, 1'b1, 7'h30));
    chk(accValue, 8'hB7);
    wr(`OFS_FILE, 32'hFFFF, `RESP_OKAY);
    ex(op(`OPC_INCSKIP, 1'b0, 7'h7F));
    rd(`OFS_STATUS);
    chk(d[`ST_ZERO], 1'b0);
    c0 = pcValue;
    ex(op(`OPC_ORLIT, 1'b0, 7'h3C));
    chk(accValue, 8'h00);
    chk(pcValue, c0 + 1);
    ex(op(`OPC_ORLIT, 1'b0, 7'h3C));
    chk(accValue, 8'h3C);
    wr(`OFS_FILE, 32'hFFFF, `RESP_OKAY);
    rd(`OFS_CYCLES);
    c0 = d;
    ex(op(`OPC_INCSKIP, 1'b1, 7'h7F));
    ex(op(`OPC_INC, 1'b0, 7'h7F));
    chk(accValue, 8'h3C);
    rd(`OFS_CYCLES);
    chk(d - c0, 32'h2);
    rd(`OFS_FILE);
    chk(d, 32'h7F00);
  endtask

  task automatic tInc;
    wr(`OFS_FILE, 32'h90FF, `RESP_OKAY);
    ex(op(`OPC_INC, 1'b0, 7'h10));
    chk(accValue, 8'h00);
    rd(`OFS_STATUS);
    chk(d[`ST_ZERO], 1'b1);
    ex(op(`OPC_INC, 1'b1, 7'h10));
    ex(op(`OPC_INC, 1'b1, 7'h10));
    rd(`OFS_FILE);
    chk(d, 32'h1001);
    chk(accValue, 8'h00);
    rd(`OFS_STATUS);
    chk(d[`ST_ZERO], 1'b0);
  endtask

  task automatic tOr;
    wr(`OFS_ACC, 32'h0F, `RESP_OKAY);
    wr(`OFS_FILE, 32'hA0F0, `RESP_OKAY);
    ex(op(`OPC_ORREG, 1'b1, 7'h20));
    rd(`OFS_FILE);
    chk(d, 32'h20FF);
    chk(accValue, 8'h0F);
    wr(`OFS_ACC, 32'h00, `RESP_OKAY);
    wr(`OFS_FILE, 32'hA100, `RESP_OKAY);
    ex(op(`OPC_ORREG, 1'b0, 7'h21));
    rd(`OFS_STATUS);
    chk(d[`ST_ZERO], 1'b1);
    ex(op(`OPC_ORREG, 1'b0, 7'h20));
    chk(accValue, 8'hFF);
  endtask

  task automatic tBr(input logic [4:0] pg, input logic [10:0] k);
    int f;
    logic [7:0] a;
    logic z;
    wr(`OFS_PAGE, {27'h0, pg}, `RESP_OKAY);
    rd(`OFS_STATUS);
    z = d[`ST_ZERO];
    rd(`OFS_CYCLES);
    c0 = d;
    a = accValue;
    f = nFl;
    ex({`BR_TAG, k});
    chk(pcValue, {pg[4:3], k});
    chk(accValue, a);
    rd(`OFS_CYCLES);
    chk(d - c0, 32'h2);
    chk(nFl - f, 1);
    rd(`OFS_STATUS);
    chk(d[`ST_ZERO], z);
  endtask

  task complete_run;
    $display("comparisons %0d, errors %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    tReset;
    tSkip;
    tInc;
    tOr;
    tBr(5'h17, 11'h7FF);
    tBr(5'h08, 11'h000);
    complete_run;
  end

  // Whole run needs a few hundred ns
  initial
  begin
    #20000;
    nFail++;
    complete_run;
  end
endmodule // tb_increment_or_branch_exec
